// ==== vcc_cal_ctrl.v ====
/*
 * oscillator calibration control: buffered/active register sets,
 * divided calibration clock, start-edge detection and result holding.
 * assumes a classic wishbone master on CORE_CLK and the pll
 * reference clock sampled as a synchronous level on REF_CLK_IN.
 */
// Chosen here: the Wishbone interface to the registers.
`include "vcc_defines.vh"

module vcc_cal_ctrl (
  input  wire        CORE_CLK,
  input  wire        SRST,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [9:0]  WB_ADR_I,
  input  wire [31:0] WB_DAT_I,
  input  wire [3:0]  WB_SEL_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire        REF_CLK_IN,
  output wire        CAL_CLK_OUT,
  output reg         CAL_BUSY,
  output reg         CAL_DONE,
  output reg  [1:0]  HOLDOVER_EN
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_DONE = 2'h2;

  reg  [7:0] cal_buf_reg;
  reg  [7:0] cal_act_reg;
  reg  [7:0] cnt_rst_reg;
  reg        start_d_reg;
  reg  [1:0] state_reg;
  reg  [7:0] tick_cnt_reg;
  reg        xfer_pulse_reg;
  wire       req;
  wire       wr;
  wire [7:0] idx;
  wire       act_start;
  wire       cal_tick;
  wire       cal_clk;
  wire       start_rise;

  assign req       = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr        = req & WB_WE_I & WB_SEL_I[0];
  assign idx       = WB_ADR_I[9:`VCC_ADDR_LSB];
  assign act_start = cal_act_reg[`VCC_START_BIT];
  assign start_rise = act_start & ~start_d_reg;

  // ----------------------------------------
  // wishbone slave, one registered ack per request, in the cycle after it
  // ----------------------------------------
  // unmapped reads return zero and writes are dropped, still acked
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      WB_ACK_O    <= 1'b0;
      WB_DAT_O    <= 32'h0000_0000;
      cal_buf_reg <= `VCC_CAL_CTRL_RST;
      cnt_rst_reg <= `VCC_CNT_RESET_RST;
      HOLDOVER_EN <= `VCC_HOLDOVER_RST;
      xfer_pulse_reg <= 1'b0;
    end else begin
      WB_ACK_O       <= req;
      xfer_pulse_reg <= 1'b0;
      if (wr) begin
        case (idx)
          `VCC_IDX_CAL_CTRL:  cal_buf_reg <= WB_DAT_I[7:0];
          `VCC_IDX_CNT_RESET: cnt_rst_reg <= WB_DAT_I[7:0];
          `VCC_IDX_HOLDOVER:  HOLDOVER_EN <= WB_DAT_I[1:0];
          `VCC_IDX_TRANSFER:  xfer_pulse_reg <= WB_DAT_I[`VCC_XFER_BIT];
          default: ;
        endcase
      end
      if (req & ~WB_WE_I) begin
        case (idx)
          `VCC_IDX_CAL_CTRL:  WB_DAT_O <= {24'h000000, cal_buf_reg};
          `VCC_IDX_CNT_RESET: WB_DAT_O <= {24'h000000, cnt_rst_reg};
          `VCC_IDX_HOLDOVER:  WB_DAT_O <= {{30{1'b0}}, HOLDOVER_EN};
          `VCC_IDX_STATUS:    WB_DAT_O <= {24'h000000, cal_act_reg[3:0], 2'h0, CAL_DONE, CAL_BUSY};
          default:            WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // active set, loaded only by the transfer strobe
  // ----------------------------------------
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      cal_act_reg <= `VCC_CAL_CTRL_RST;
      start_d_reg <= 1'b0;
    end else begin
      start_d_reg <= act_start;
      if (xfer_pulse_reg)
        cal_act_reg <= cal_buf_reg;
    end
  end

  // ----------------------------------------
  // calibration clock divider
  // ----------------------------------------
  vcc_clk_div u_div (
    .clk      (CORE_CLK),
    .srst     (SRST),
    .ref_in   (REF_CLK_IN),
    .run      (1'b1),
    .sel      (cal_act_reg[`VCC_DIV_HI:`VCC_DIV_LO]),
    .cal_clk  (cal_clk),
    .cal_tick (cal_tick)
  );

  assign CAL_CLK_OUT = cal_clk;

  // ----------------------------------------
  // calibration sequencer
  // ----------------------------------------
  // fixed count of calibration clocks, so length scales with ratio
  always @(posedge CORE_CLK) begin
    if (SRST) begin
      state_reg    <= ST_IDLE;
      tick_cnt_reg <= 8'h00;
      CAL_BUSY     <= 1'b0;
      CAL_DONE     <= 1'b0;
    end else if (~act_start) begin
      state_reg    <= ST_IDLE;
      tick_cnt_reg <= 8'h00;
      CAL_BUSY     <= 1'b0;
      CAL_DONE     <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_rise) begin
            state_reg    <= ST_RUN;
            tick_cnt_reg <= 8'h00;
            CAL_BUSY     <= 1'b1;
          end
        end
        ST_RUN: begin
          if (cal_tick) begin
            if (tick_cnt_reg == `VCC_CAL_CYCLES - 8'h01) begin
              state_reg <= ST_DONE;
              CAL_BUSY  <= 1'b0;
              CAL_DONE  <= 1'b1;
            end else begin
              tick_cnt_reg <= tick_cnt_reg + 8'h01;
            end
          end
        end
        ST_DONE: state_reg <= ST_DONE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// ==== vcc_cal_ctrl_tb_top.sv ====
/* self-checking bench of the calibration control block
   assumes a reference of four core cycles made here */
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; $display("BAD %0t %h %h", $time, a, b); end end
module vcc_cal_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'h0;
  logic        srst = 1'h1;
  logic        cyc = 1'h0;
  logic        stb = 1'h0;
  logic        we = 1'h0;
  logic [9:0]  adr = 10'h0;
  logic [31:0] dat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic        ref_in = 1'h0;
  logic [1:0]  rc = 2'h0;
  logic [31:0] dout;
  logic        ack;
  logic        cal_clk;
  logic        busy;
  logic        done;
  logic [1:0]  hold;
  logic [7:0]  rdat;
  logic        pc;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc_cnt = 0;
  int          n;
  int          r;
  vcc_cal_ctrl vcc_cal_ctrl_i (.CORE_CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(sel), .WB_DAT_O(dout), .WB_ACK_O(ack),
    .REF_CLK_IN(ref_in), .CAL_CLK_OUT(cal_clk), .CAL_BUSY(busy), .CAL_DONE(done), .HOLDOVER_EN(hold));
  // ------------------------------
  // clock, reference and timeout
  // ------------------------------
  always #25 clk = ~clk;
  // reference at a quarter of core rate; run needs under 10k cycles
  always @(posedge clk) begin
    rc <= rc + 2'h1;
    ref_in <= rc[1];
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      wrap_up;
    end
  end
  // ------------------------------
  // bus tasks
  // ------------------------------
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {idx, 2'h0};
    dat <= {24'h0, d};
    sel <= 4'hf;
    @(posedge clk);
    while (ack !== 1'h1) @(posedge clk);
    rdat = dout[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    wb(1'h0, idx, 8'h0);
    `CHK(rdat, e)
  endtask
  // transfer strobe, then let the active set load
  task automatic xfer;
    wb(1'h1, 8'h20, 8'h01);
    repeat (3) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d bad %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    rd(8'h18, 8'h06);
    rd(8'h22, 8'h60);
    rd(8'h19, 8'h00);
    rd(8'h30, 8'h00);
    $display("reset test done");
    wb(1'h1, 8'h18, 8'h03);
    rd(8'h22, 8'h60);
    `CHK(busy, 1'h0)
    $display("buffer test done");
    for (int c = 0; c < 4; c++) begin
      wb(1'h1, 8'h18, {5'h0, c[1:0], 1'h0});
      xfer;
      wb(1'h1, 8'h18, {5'h0, c[1:0], 1'h1});
      xfer;
      n = 0;
      while (busy !== 1'h1 && n < 8) begin
        @(posedge clk);
        n++;
      end
      `CHK(busy, 1'h1)
      n = 0;
      r = 0;
      pc = cal_clk;
      while (busy === 1'h1 && n < 9000) begin
        @(posedge clk);
        n++;
        if (cal_clk === 1'h1 && pc === 1'h0) r++;
        pc = cal_clk;
      end
      `CHK((n + (256 << c)) / (512 << c), 1)
      `CHK(r > 60 && r < 68, 1'h1)
      `CHK(done, 1'h1)
      xfer;
      `CHK(busy, 1'h0)
      wb(1'h1, 8'h18, {5'h0, c[1:0], 1'h0});
      xfer;
      `CHK(done, 1'h0)
      $display("divider test done");
    end
    wb(1'h1, 8'h21, 8'h03);
    `CHK(hold, 2'h3)
    rd(8'h21, 8'h03);
    wb(1'h1, 8'h21, 8'h00);
    `CHK(hold, 2'h0)
    $display("holdover test done");
    wrap_up;
  end
endmodule

// ==== vcc_cal_sva.sv ====
/* port assertions of the calibration control top
   assumes the bind below and a classic wishbone master */
module vcc_cal_sva (
  input wire logic       CORE_CLK,
  input wire logic       SRST,
  input wire logic       WB_CYC_I,
  input wire logic       WB_STB_I,
  input wire logic       WB_WE_I,
  input wire logic       WB_ACK_O,
  input wire logic       CAL_CLK_OUT,
  input wire logic       CAL_BUSY,
  input wire logic       CAL_DONE,
  input wire logic [1:0] HOLDOVER_EN
);
  // -------------------------------
  // bus and calibration relations
  // -------------------------------
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  // a taken request, then its single-cycle answer
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ans;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  chk_ack_next: assert property (s_req |=> s_ans)
    else $error("ack late or long");
  chk_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  chk_reset_vals: assert property ($fell(SRST) |-> !HOLDOVER_EN && !CAL_BUSY && !CAL_DONE && !CAL_CLK_OUT)
    else $error("outputs not at reset level");
  chk_busy_fresh: assert property ($rose(CAL_BUSY) |-> !CAL_DONE)
    else $error("old result kept at start");
  chk_busy_min: assert property ($rose(CAL_BUSY) |-> CAL_BUSY [*8])
    else $error("calibration too short");
  chk_done_cause: assert property ($rose(CAL_DONE) |-> $past(CAL_BUSY))
    else $error("done without calibration");
  // a divided clock can never toggle on two edges running
  chk_clk_spacing: assert property ($changed(CAL_CLK_OUT) |=> $stable(CAL_CLK_OUT))
    else $error("calibration clock too fast");
  chk_hold_write: assert property ($changed(HOLDOVER_EN) |-> $past(WB_CYC_I && WB_STB_I && WB_WE_I))
    else $error("holdover moved without write");
endmodule
bind vcc_cal_ctrl vcc_cal_sva vcc_cal_sva_i (.CORE_CLK, .SRST, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
  .WB_ACK_O, .CAL_CLK_OUT, .CAL_BUSY, .CAL_DONE, .HOLDOVER_EN);

// ==== vcc_clk_div.v ====
/*
 * divides the reference clock by 2, 4, 8 or 16 into a calibration
 * clock level and a one-cycle tick on each calibration clock rise.
 * assumes the reference arrives as a synchronous level on core clock.
 */
`include "vcc_defines.vh"

module vcc_clk_div (
  input  wire       clk,
  input  wire       srst,
  input  wire       ref_in,
  input  wire       run,
  input  wire [1:0] sel,
  output reg        cal_clk,
  output reg        cal_tick
);

  reg                   ref_d_reg;
  reg [`VCC_CNT_W-1:0]  cnt_reg;
  wire                  ref_rise;
  wire [`VCC_CNT_W-1:0] half;

  // ----------------------------------------
  // half period in reference rises, minus one, per code
  // ----------------------------------------
  function [`VCC_CNT_W-1:0] half_of;
    input [1:0] code;
    begin
      case (code)
        `VCC_DIV2: half_of = 4'h0;
        `VCC_DIV4: half_of = 4'h1;
        `VCC_DIV8: half_of = 4'h3;
        default:   half_of = 4'h7;
      endcase
    end
  endfunction

  assign ref_rise = ref_in & ~ref_d_reg;
  assign half     = half_of(sel);

  // toggle the output every (ratio/2) reference rises
  always @(posedge clk) begin
    if (srst | ~run) begin
      ref_d_reg <= 1'b0;
      cnt_reg   <= 4'h0;
      cal_clk   <= 1'b0;
      cal_tick  <= 1'b0;
    end else begin
      ref_d_reg <= ref_in;
      cal_tick  <= 1'b0;
      if (ref_rise) begin
        if (cnt_reg >= half) begin
          cnt_reg  <= 4'h0;
          cal_clk  <= ~cal_clk;
          cal_tick <= ~cal_clk;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end

endmodule

// ==== vcc_defines.vh ====
/*
 * shared constants of the oscillator calibration control block:
 * register offsets, field positions, reset values, codes and counts.
 * assumes inclusion by bare name from each design file.
 */
`ifndef VCC_DEFINES_VH
`define VCC_DEFINES_VH

// ----------------------------------------
// register map (word offsets, byte address = 4 * index)
// ----------------------------------------
`define VCC_IDX_CNT_RESET      8'h19
`define VCC_IDX_CAL_CTRL       8'h18
`define VCC_IDX_TRANSFER       8'h20
`define VCC_IDX_HOLDOVER       8'h21
`define VCC_IDX_STATUS         8'h22
`define VCC_ADDR_LSB           2

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define VCC_START_BIT          0
`define VCC_DIV_HI             2
`define VCC_DIV_LO             1
`define VCC_CAL_CTRL_RST       8'h06
`define VCC_CNT_RESET_RST      8'h00
`define VCC_HOLDOVER_RST       2'h0
`define VCC_XFER_BIT           0

// ----------------------------------------
// divider codes and calibration length
// ----------------------------------------
`define VCC_DIV2               2'h0
`define VCC_DIV4               2'h1
`define VCC_DIV8               2'h2
`define VCC_DIV16              2'h3
`define VCC_CAL_CYCLES         8'h40
`define VCC_CNT_W              4

`endif
